// [design/abhp_pkg.sv]
// constants and carrier types of the adc byte-wide host port
package abhp_pkg;
   localparam int unsigned RESULT_W = 10;
   localparam int unsigned BUS_W = 8;
   localparam int unsigned CFG_W = 8;
   // control bit that selects external acquisition when set
   localparam int unsigned CFG_EXT_ACQ_BIT = 5;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   // hold after this many falling conversion-clock edges in internal acquisition
   localparam logic [2:0] ACQ_FALL_EDGES = 3'h4;
   // internal oscillator half period in system clocks when no external clock is used
   localparam logic [7:0] INT_CLK_HALF = 8'h02;
   localparam logic [3:0] CONV_STEPS = 4'ha;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic high_byte_select;
   } abhp_strobes_s;

   typedef struct packed {
      logic [7:0] data_out;
      logic [7:0] data_oe_n;
      logic done_n_out;
      logic done_oe_n;
   } abhp_drive_s;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACQ_INT,
      ST_ACQ_EXT,
      ST_CONV
   } abhp_state_e;
endpackage : abhp_pkg

// [design/abhp_sar.sv]
// successive-approximation sequencer: one step per conversion-clock fall
`timescale 1ns/1ps
`default_nettype none
module abhp_sar (
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic conv_fall,
   input wire logic comp_high,
   output logic busy,
   output logic done,
   output logic [9:0] result
);
   logic [3:0] step_r;
   logic [9:0] trial_r;
   logic [9:0] bit_w;

   assign bit_w = 10'h200 >> (4'h9 - (step_r - 4'h1));
   assign busy = (step_r != 4'h0);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         step_r <= 4'h0;
         trial_r <= 10'h000;
         result <= abhp_pkg::RESULT_RESET;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            step_r <= abhp_pkg::CONV_STEPS;
            trial_r <= 10'h200;
         end else if (busy && conv_fall) begin
            step_r <= step_r - 4'h1;
            if (step_r == 4'h1) begin
               result <= comp_high ? trial_r : (trial_r & ~bit_w);
               done <= 1'b1;
            end else begin
               trial_r <= (comp_high ? trial_r : (trial_r & ~bit_w)) | (bit_w >> 1);
            end
         end
      end
   end
endmodule : abhp_sar
`default_nettype wire

// [design/abhp_port.sv]
// byte-wide host port of a 10-bit converter
// Behaviour
// (R1) high byte select high gives upper 2 bits, low gives lower 8.
// (R2) lowest two lines carry bits 1,0 or bits 9,8 by select.
// (R3) done output goes low once a conversion finishes and result is ready.
// (R4) read only with chip select low, started by read strobe falling edge.
// (R5) internal acquisition: write rise latches config and starts acquisition plus conversion.
// (R6) external acquisition: first write rise after configuration ends acquisition, starts conversion.
// (R7) host gives continuous clock in external mode, static level in internal.
// (R8) chip select high puts data and done outputs in high impedance.
// (R9) track on write rise; hold on next write rise or fourth clock fall.
// (R10) host keeps write high until first conversion clock fall in internal acquisition.
// (R11) result stays stable until the next conversion completes.
`timescale 1ns/1ps
`default_nettype none
module abhp_port (
   input wire logic clk,
   input wire logic resetn,
   input wire abhp_pkg::abhp_strobes_s strobes,
   input wire logic [7:0] data_in,
   input wire logic conv_clk_pin,
   input wire logic ext_clk_mode,
   input wire logic comp_high,
   output abhp_pkg::abhp_drive_s drive,
   output logic [7:0] config_byte,
   output logic tracking,
   output logic converting
);
   abhp_pkg::abhp_state_e state_r, state_nxt;
   logic wr_q_r, rd_q_r, pin_q_r, int_clk_r;
   logic [7:0] int_div_r;
   logic [2:0] fall_cnt_r;
   logic reading_r;
   logic done_n_r;
   logic [7:0] data_r;
   logic wr_rise, rd_fall, conv_clk, conv_fall, cs_act, start_conv;
   logic in_acq_int, in_acq_ext, acq_fall, hold_ext, hold_int;
   logic cfg_load, next_ext, done_clr, read_close, int_wrap, bus_drive;
   abhp_pkg::abhp_state_e acq_nxt;
   logic sar_busy, sar_done;
   logic [9:0] result;
   logic [7:0] byte_sel;

   function automatic logic [7:0] pick_byte(input logic [9:0] r, input logic hi);
      pick_byte = hi ? {6'h00, r[9:8]} : r[7:0];
   endfunction : pick_byte

   // mode bit of a control byte: high selects external acquisition
   function automatic logic cfg_ext(input logic [7:0] b);
      cfg_ext = b[abhp_pkg::CFG_EXT_ACQ_BIT];
   endfunction : cfg_ext

   // strobe edges compare the live strobe with the previous sample, seen in the same clock
   assign cs_act = !strobes.cs_n;
   assign wr_rise = cs_act && strobes.wr_n && !wr_q_r;
   assign rd_fall = cs_act && !strobes.rd_n && rd_q_r;
   assign conv_clk = ext_clk_mode ? conv_clk_pin : int_clk_r; // R7
   assign conv_fall = pin_q_r && !conv_clk;
   assign next_ext = cfg_ext(data_in);
   assign acq_nxt = next_ext ? abhp_pkg::ST_ACQ_EXT : abhp_pkg::ST_ACQ_INT;
   assign byte_sel = pick_byte(result, strobes.high_byte_select); // R1 R2

   // state decode
   assign in_acq_int = (state_r == abhp_pkg::ST_ACQ_INT);
   assign in_acq_ext = (state_r == abhp_pkg::ST_ACQ_EXT);

   // a write that ends an external acquisition must not reload the mode
   assign cfg_load = wr_rise && !in_acq_ext; // R5
   assign acq_fall = in_acq_int && conv_fall;

   // start conversion: hold point of the track-and-hold
   assign hold_ext = in_acq_ext && wr_rise; // R6 R9
   assign hold_int = acq_fall && !wr_rise && (fall_cnt_r == abhp_pkg::ACQ_FALL_EDGES - 3'h1); // R9
   assign start_conv = hold_ext || hold_int;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         abhp_pkg::ST_IDLE: begin
            if (wr_rise) begin
               state_nxt = acq_nxt; // R5
            end
         end
         abhp_pkg::ST_ACQ_INT: begin
            if (wr_rise) begin
               state_nxt = acq_nxt; // R5
            end else if (hold_int) begin
               state_nxt = abhp_pkg::ST_CONV;
            end
         end
         abhp_pkg::ST_ACQ_EXT: begin
            if (hold_ext) begin
               state_nxt = abhp_pkg::ST_CONV; // R6
            end
         end
         abhp_pkg::ST_CONV: begin
            if (wr_rise) begin
               state_nxt = acq_nxt; // R5
            end else if (sar_done) begin
               state_nxt = abhp_pkg::ST_IDLE;
            end
         end
      endcase
   end

   assign tracking = in_acq_int || in_acq_ext; // R9
   assign converting = sar_busy;

   // sequencer: starts at the hold point, one step per conversion-clock fall
   abhp_sar u_sar (
      .clk(clk),
      .resetn(resetn),
      .start(start_conv),
      .conv_fall(conv_fall),
      .comp_high(comp_high),
      .busy(sar_busy),
      .done(sar_done),
      .result(result) // R11
   );

   // strobe history, reset to the idle high level so no false edge follows reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q_r <= 1'b1;
         rd_q_r <= 1'b1;
      end else begin
         wr_q_r <= strobes.wr_n;
         rd_q_r <= strobes.rd_n;
      end
   end

   // conversion clock history for fall detection
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_q_r <= 1'b0;
      end else begin
         pin_q_r <= conv_clk;
      end
   end

   // internal oscillator stand-in
   assign int_wrap = (int_div_r == abhp_pkg::INT_CLK_HALF - 8'h01);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_div_r <= 8'h00;
         int_clk_r <= 1'b0;
      end else if (int_wrap) begin
         int_div_r <= 8'h00;
         int_clk_r <= !int_clk_r;
      end else begin
         int_div_r <= int_div_r + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= abhp_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         config_byte <= abhp_pkg::CFG_RESET;
      end else if (cfg_load) begin
         config_byte <= data_in; // R5
      end
   end

   // falling conversion-clock edges seen since the configuration write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fall_cnt_r <= 3'h0;
      end else if (wr_rise) begin
         fall_cnt_r <= 3'h0;
      end else if (acq_fall) begin
         fall_cnt_r <= fall_cnt_r + 3'h1;
      end
   end

   assign done_clr = rd_fall || wr_rise;
   assign read_close = !cs_act || strobes.rd_n;

   // done flag: completion sets, a read or a new write clears; set wins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         done_n_r <= 1'b1;
      end else if (sar_done) begin
         done_n_r <= 1'b0; // R3
      end else if (done_clr) begin
         done_n_r <= 1'b1;
      end
   end

   // a read stays open until the read strobe or chip select rises
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reading_r <= 1'b0;
      end else if (read_close) begin
         reading_r <= 1'b0;
      end else if (rd_fall) begin
         reading_r <= 1'b1; // R4
      end
   end

   // selected half registered; the result itself holds until the next completion
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         data_r <= 8'h00;
      end else begin
         data_r <= byte_sel; // R1
      end
   end

   // pins: data and done float whenever chip select is high
   assign bus_drive = cs_act && reading_r && !strobes.rd_n; // R4
   assign drive.data_out = data_r;
   assign drive.data_oe_n = bus_drive ? 8'h00 : 8'hff; // R8
   assign drive.done_n_out = done_n_r;
   assign drive.done_oe_n = !cs_act; // R8
endmodule : abhp_port
`default_nettype wire

// [sim/abhp_monitor.sv]
// assertion checker of the host port
`timescale 1ns/1ps
`default_nettype none
module abhp_monitor (
   input wire logic clk,
   input wire logic resetn,
   input wire abhp_pkg::abhp_strobes_s strobes,
   input wire logic [7:0] data_in,
   input wire abhp_pkg::abhp_drive_s drive,
   input wire logic [7:0] config_byte,
   input wire logic tracking,
   input wire logic converting
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_OE_CS: assert property (strobes.cs_n |-> drive.data_oe_n == 8'hff && drive.done_oe_n)
      else $error("outputs driven while deselected");
   AST_READ_OE: assert property ((!strobes.cs_n && $fell(strobes.rd_n)) ##1 (!strobes.cs_n && !strobes.rd_n)
      |-> drive.data_oe_n == 8'h00) else $error("read not driven");
   AST_RD_OFF: assert property (strobes.rd_n |-> drive.data_oe_n == 8'hff)
      else $error("bus driven without read");
   AST_HIGH_UPPER: assert property (strobes.high_byte_select && $past(strobes.high_byte_select)
      |-> drive.data_out[7:2] == 6'h00) else $error("upper lines not zero");
   AST_WR_CFG: assert property (!strobes.cs_n && $rose(strobes.wr_n) && !(tracking && config_byte[5])
      |=> config_byte == $past(data_in) && tracking) else $error("config write lost");
   AST_EXT_START: assert property (!strobes.cs_n && $rose(strobes.wr_n) && tracking && config_byte[5]
      |=> $stable(config_byte) ##[0:2] converting) else $error("external start failed");
   AST_DONE_LOW: assert property ($fell(converting) |-> ##[0:2] !drive.done_n_out)
      else $error("done not flagged");
   AST_RESULT_HOLD: assert property ((!converting && $stable(strobes.high_byte_select)) [*3]
      |-> $stable(drive.data_out)) else $error("result moved");
endmodule : abhp_monitor
bind abhp_port abhp_monitor mon (.clk, .resetn, .strobes, .data_in, .drive, .config_byte, .tracking, .converting);
`default_nettype wire

// [sim/abhp_far_model.sv]
// far-side model: conversion clock pin and comparator
`timescale 1ns/1ps
`default_nettype none
module abhp_far_model (
   input wire logic clk,
   input wire logic ext_clk_mode,
   input wire logic want_high,
   output logic conv_clk_pin,
   output logic comp_high
);
   logic [1:0] div_r = 2'h0;
   logic pin_r = 1'b0;
   always_ff @(posedge clk) begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3)
         pin_r <= ext_clk_mode & ~pin_r;
   end
   assign conv_clk_pin = pin_r;
   assign comp_high = want_high;
endmodule : abhp_far_model
`default_nettype wire

// [sim/adc_byte_wide_host_port_test.sv]
// self-checking bench of the host port
`timescale 1ns/1ps
`default_nettype none
module adc_byte_wide_host_port_test;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   abhp_pkg::abhp_strobes_s strobes = 4'he;
   logic [7:0] data_in = 8'h00;
   logic ext_clk_mode = 1'b0;
   logic want_high = 1'b1;
   logic conv_clk_pin;
   logic comp_high;
   abhp_pkg::abhp_drive_s drive;
   logic [7:0] config_byte;
   logic tracking;
   logic converting;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   abhp_far_model far (.clk, .ext_clk_mode, .want_high, .conv_clk_pin, .comp_high);
   abhp_port dut (.clk, .resetn, .strobes, .data_in, .conv_clk_pin, .ext_clk_mode, .comp_high, .drive,
      .config_byte, .tracking, .converting);
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : step
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_cfg(input logic [7:0] b);
      strobes.cs_n = 1'b0;
      strobes.wr_n = 1'b0;
      data_in = b;
      step(2);
      strobes.wr_n = 1'b1;
      step(2);
      strobes.cs_n = 1'b1;
      step(1);
   endtask : wr_cfg
   task automatic rd(input logic hbs, input logic [9:0] exp);
      strobes.cs_n = 1'b0;
      strobes.high_byte_select = hbs;
      step(1);
      strobes.rd_n = 1'b0;
      step(2);
      chk({2'h0, drive.data_out}, exp);
      chk({2'h0, drive.data_oe_n}, 10'h000);
      strobes.rd_n = 1'b1;
      step(1);
      strobes.cs_n = 1'b1;
      step(1);
   endtask : rd
   task automatic wait_done();
      int n;
      n = 0;
      while (drive.done_n_out !== 1'b0 && n < 400) begin
         step(1);
         n++;
      end
      chk({9'h0, drive.done_n_out}, 10'h000);
   endtask : wait_done
   task automatic t_deselect();
      strobes.rd_n = 1'b0;
      step(2);
      chk({2'h0, drive.data_oe_n}, 10'h0ff);
      chk({9'h0, drive.done_oe_n}, 10'h001);
      strobes.rd_n = 1'b1;
      step(1);
      $display("deselect test done");
   endtask : t_deselect
   task automatic t_internal();
      wr_cfg(8'h8a);
      chk({2'h0, config_byte}, 10'h08a);
      chk({9'h0, tracking}, 10'h001);
      wait_done();
      rd(1'b1, 10'h003);
      rd(1'b0, 10'h0ff);
      rd(1'b1, 10'h003);
      $display("internal acquisition test done");
   endtask : t_internal
   task automatic t_external();
      ext_clk_mode = 1'b1;
      want_high = 1'b0;
      wr_cfg(8'h20);
      step(20);
      chk({9'h0, tracking}, 10'h001);
      wr_cfg(8'h55);
      chk({2'h0, config_byte}, 10'h020);
      chk({9'h0, converting}, 10'h001);
      chk({9'h0, tracking}, 10'h000);
      wait_done();
      rd(1'b0, 10'h000);
      rd(1'b1, 10'h000);
      $display("external acquisition test done");
   endtask : t_external
   task automatic give_verdict();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (12) @(posedge clk);
      #2;
      resetn = 1'b1;
      step(1);
      t_deselect();
      t_internal();
      t_external();
      give_verdict();
   end
endmodule : adc_byte_wide_host_port_test
`default_nettype wire
